// >>> hdl/sea_regs.vh
`ifndef SEA_REGS_VH
`define SEA_REGS_VH

// ============================================================
// Timing
`define SEA_CLK_NS        10
`define SEA_STEP_NS       200
`define SEA_STEP_CYC      ((`SEA_STEP_NS + `SEA_CLK_NS - 1) / `SEA_CLK_NS)

// ============================================================
// Register byte offsets
`define SEA_OFF_CTRL      8'h00
`define SEA_OFF_STATUS    8'h04
`define SEA_OFF_ARG       8'h08
`define SEA_OFF_ADDR      8'h0c
`define SEA_OFF_CMD       8'h10
`define SEA_OFF_RDATA     8'h14
`define SEA_OFF_MDC       8'h18
`define SEA_OFF_MAC       8'h1c
`define SEA_OFF_WDAT_HI   4'h2

// ============================================================
// Field positions and reset values
`define SEA_CTRL_TEAR     0
`define SEA_CTRL_SUPER    1
`define SEA_CTRL_SIDX_LSB 2
`define SEA_CTRL_SIDX_MSB 4
`define SEA_CTRL_RST      5'h00
`define SEA_AR_PWEN       0
`define SEA_AR_PWSET_LSB  1
`define SEA_AR_PWSET_MSB  3
`define SEA_AR_AUTHEN     4
`define SEA_AR_KEY_LSB    5
`define SEA_AR_KEY_MSB    6
`define SEA_AR_ENCREQ     7
`define SEA_AR_WLOCK      8
`define SEA_AR_PROG       9
`define SEA_AR_MODF       10
`define SEA_ERASED        8'hff

// ============================================================
// Commands, modes, limits
`define SEA_OP_NOP        4'h0
`define SEA_OP_SECURE     4'h1
`define SEA_OP_PW         4'h2
`define SEA_OP_AUTH       4'h3
`define SEA_OP_ENC        4'h4
`define SEA_OP_WRITE      4'h5
`define SEA_OP_READ       4'h6
`define SEA_OP_CFG_AR     4'h7
`define SEA_OP_CFG_PW     4'h8
`define SEA_MODE_STD      2'h0
`define SEA_MODE_AUTH     2'h1
`define SEA_MODE_ENC      2'h2
`define SEA_TRIAL_MAX     3'h4
`define SEA_LINK_PULSES   3'h5
`define SEA_TEAR_LAST     4'h7
`define SEA_KEY_BASE      4'h8
`define SEA_SC_TRIAL      4'hc

`endif

// >>> hdl/sea_access_ctrl.v
// Function
// - Standard at power-up; auth, then encryption.
// - Auth or encryption modes demand a MAC.
// - MAC mismatch discards command, drops to standard.
// - Standard mode offers readable modification detection code.
// - Tear protection: at most eight bytes, slower.
// - Tear writes go to buffer, then target.
// - Interrupted copy resumes from buffer at power-up.
// - Write lock: page's first byte guards page.
// - Bit 0 locks guard byte; bits only clear.
// - Write-locked zone writes only the first byte.
// - Password holds until new one or reset.
// - Eight password sets; write password grants read.
// - Four keys; authentication holds until restart, reset.
// - Failed authentication cancels earlier success.
// - Four wrong attempts lock that trial counter.
// - Encryption-required zone needs encryption mode active.
// - Supervisor password may change all password sets.
// - Modify-forbidden zone rejects every write.
// - Program-only zone: bits only go one-to-zero.
// - Configuration access needs the secure code first, except supervisor password changes.
`timescale 1ns/10ps
`include "sea_regs.vh"

module sea_access_ctrl
#(
  parameter [23:0] SECURE_CODE = 24'h5a_c3_17  // Value is arbitrary
)
(
  input  wire        clock,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        link_clk,
  input  wire        card_rst,
  input  wire        nv_erase,
  input  wire [23:0] crypto_resp,
  input  wire [23:0] crypto_mac,
  output reg  [1:0]  sec_mode,
  output reg         dev_busy
);

  localparam [2:0] S_START  = 3'h0;
  localparam [2:0] S_IDLE   = 3'h1;
  localparam [2:0] S_EXEC   = 3'h2;
  localparam [2:0] S_BUF    = 3'h3;
  localparam [2:0] S_COPY   = 3'h4;
  localparam [2:0] S_DIRECT = 3'h5;
  localparam integer STEP_N    = `SEA_STEP_CYC - 1;
  localparam [7:0]   STEP_LAST = STEP_N[7:0];

  // ==========================================================
  // Nonvolatile storage (kept across rst, cleared by nv_erase)
  reg [7:0]   mem [0:1023];
  reg [7:0]   tb_dat [0:7];
  reg [9:0]   tb_base;
  reg [2:0]   tb_last;
  reg         pend;
  reg [10:0]  ar [0:7];
  reg [23:0]  pw_w [0:7];
  reg [23:0]  pw_r [0:7];

  // ==========================================================
  // Control state
  reg [2:0]   state;
  reg [3:0]   ptr;
  reg [3:0]   last;
  reg         auth_ok;
  reg [1:0]   key_idx;
  reg         pw_ok;
  reg         pw_wr;
  reg [2:0]   pw_idx;
  reg         sc_ok;
  reg         last_ok;
  reg [2:0]   last_trials;
  reg [4:0]   ctrl;
  reg [23:0]  arg;
  reg [19:0]  addr;
  reg [23:0]  mac_rx;
  reg [127:0] wdat;
  reg [3:0]   cmd_op;
  reg [2:0]   cmd_idx;
  reg         cmd_sel;
  reg [7:0]   rdata;
  reg [31:0]  mdc;
  reg [2:0]   trials [0:12];
  reg         crst_s1;
  reg         crst_s2;
  reg         crst_s3;
  reg         crst_act;
  reg         scl_s1;
  reg         scl_s2;
  reg         scl_s3;
  reg         scl_lvl;
  reg [2:0]   scl_cnt;
  reg [7:0]   div_cnt;
  reg         tick;
  integer     k;

  // ==========================================================
  // Pin synchronisers, link edge counter and write-step divider
  // Link clock is only sampled; five rising edges arm the command path
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      crst_s1  <= 1'b0;
      crst_s2  <= 1'b0;
      crst_s3  <= 1'b0;
      crst_act <= 1'b0;
      scl_s1   <= 1'b0;
      scl_s2   <= 1'b0;
      scl_s3   <= 1'b0;
      scl_lvl  <= 1'b0;
      scl_cnt  <= 3'h0;
      div_cnt  <= 8'h00;
      tick     <= 1'b0;
    end
    else
    begin
      crst_s1 <= card_rst;
      crst_s2 <= crst_s1;
      crst_s3 <= crst_s2;
      if (crst_s2 == crst_s3)
        crst_act <= crst_s3;
      scl_s1 <= link_clk;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      if (scl_s2 == scl_s3)
        scl_lvl <= scl_s3;
      if (scl_s2 == scl_s3 && scl_s3 && !scl_lvl && scl_cnt != `SEA_LINK_PULSES)
        scl_cnt <= scl_cnt + 3'h1;
      tick <= (div_cnt == STEP_LAST);
      div_cnt <= (div_cnt == STEP_LAST) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  wire link_ready = (scl_cnt == `SEA_LINK_PULSES);

  // ==========================================================
  // Zone access decision for the addressed zone
  wire [10:0] arz      = ar[addr[9:7]];
  wire        key_ok   = !arz[`SEA_AR_AUTHEN] ||
                         (auth_ok && key_idx == arz[`SEA_AR_KEY_MSB:`SEA_AR_KEY_LSB]);
  wire        pwset_ok = pw_ok && pw_idx == arz[`SEA_AR_PWSET_MSB:`SEA_AR_PWSET_LSB];
  wire        pw_rd_ok = !arz[`SEA_AR_PWEN] || pwset_ok;
  wire        pw_wr_ok = !arz[`SEA_AR_PWEN] || (pwset_ok && pw_wr);
  wire        enc_ok   = !arz[`SEA_AR_ENCREQ] || sec_mode == `SEA_MODE_ENC;
  wire        rd_ok    = key_ok && pw_rd_ok && enc_ok;
  wire        wr_ok    = key_ok && pw_wr_ok && enc_ok && !arz[`SEA_AR_MODF];
  wire        tear     = ctrl[`SEA_CTRL_TEAR];
  wire        super_ok = ctrl[`SEA_CTRL_SUPER] && pw_ok &&
                         pw_idx == ctrl[`SEA_CTRL_SIDX_MSB:`SEA_CTRL_SIDX_LSB];

  // Write length: one byte when locked, eight at most with tearing on
  wire [3:0]  len_last = arz[`SEA_AR_WLOCK] ? 4'h0 :
                         (tear && addr[19:16] > `SEA_TEAR_LAST) ?
                         `SEA_TEAR_LAST : addr[19:16];

  // ==========================================================
  // Command checks: MAC, trial counter, comparison
  wire        mac_ok = (sec_mode == `SEA_MODE_STD) || (mac_rx == crypto_mac);
  wire [3:0]  tix    = (cmd_op == `SEA_OP_PW)     ? {1'b0, cmd_idx} :
                       (cmd_op == `SEA_OP_AUTH)   ? `SEA_KEY_BASE + {2'h0, cmd_idx[1:0]} :
                       (cmd_op == `SEA_OP_ENC)    ? `SEA_KEY_BASE + {2'h0, key_idx} :
                       `SEA_SC_TRIAL;
  wire [2:0]  trial_now = trials[tix];
  wire        locked    = (trial_now == `SEA_TRIAL_MAX);
  wire [23:0] pw_ref    = cmd_sel ? pw_w[cmd_idx] : pw_r[cmd_idx];
  wire        cmp_ok    = (cmd_op == `SEA_OP_SECURE) ? (arg == SECURE_CODE) :
                          (cmd_op == `SEA_OP_PW)     ? (arg == pw_ref) :
                          (cmd_op == `SEA_OP_AUTH)   ? (arg == crypto_resp) :
                          (auth_ok && arg == crypto_resp);
  wire        is_trial  = (cmd_op == `SEA_OP_SECURE) || (cmd_op == `SEA_OP_PW) ||
                          (cmd_op == `SEA_OP_AUTH) || (cmd_op == `SEA_OP_ENC);

  // ==========================================================
  // Per-step byte value, honouring lock and program-only rules
  wire [9:0]  step_a = (state == S_COPY) ? tb_base + {6'h00, ptr} : addr[9:0] + {6'h00, ptr};
  wire [10:0] sar    = ar[step_a[9:7]];
  wire [7:0]  old_b  = mem[step_a];
  wire [7:0]  perm_b = mem[{step_a[9:3], 3'h0}];
  wire [7:0]  new_b  = wdat[{ptr, 3'h0} +: 8];
  wire [7:0]  prog_b = sar[`SEA_AR_PROG] ? (old_b & new_b) : new_b;
  reg  [7:0]  wval;

  // Guard byte may only lose bits, and locks itself via bit 0
  always @*
  begin
    wval = prog_b;
    if (sar[`SEA_AR_WLOCK])
    begin
      if (step_a[2:0] == 3'h0)
        wval = perm_b[0] ? (old_b & new_b) : old_b;
      else
        wval = perm_b[step_a[2:0]] ? prog_b : old_b;
    end
  end

  wire in_exec = (state == S_EXEC);
  wire mem_we  = tick && (state == S_DIRECT || state == S_COPY);
  wire [7:0] mem_wd = (state == S_COPY) ? tb_dat[ptr[2:0]] : wval;
  wire tb_we   = tick && (state == S_BUF);
  wire tb_set  = in_exec && mac_ok && cmd_op == `SEA_OP_WRITE && wr_ok && tear;
  wire pend_set = tb_we && ptr == last;
  wire pend_clr = mem_we && state == S_COPY && ptr == {1'b0, tb_last};
  wire ar_we   = in_exec && mac_ok && cmd_op == `SEA_OP_CFG_AR && sc_ok;
  wire pw_we   = in_exec && mac_ok && cmd_op == `SEA_OP_CFG_PW && (sc_ok || super_ok);

  // ==========================================================
  // Nonvolatile storage: no async reset, so a power loss keeps it
  always @(posedge clock)
  begin
    if (nv_erase)
    begin
      for (k = 0; k < 1024; k = k + 1)
        mem[k] <= `SEA_ERASED;
      for (k = 0; k < 8; k = k + 1)
      begin
        tb_dat[k] <= `SEA_ERASED;
        ar[k]     <= 11'h000;
        pw_w[k]   <= 24'h000000;
        pw_r[k]   <= 24'h000000;
      end
      tb_base <= 10'h000;
      tb_last <= 3'h0;
      pend    <= 1'b0;
    end
    else
    begin
      if (mem_we)
        mem[step_a] <= mem_wd;
      if (tb_we)
        tb_dat[ptr[2:0]] <= wval;
      if (tb_set)
      begin
        tb_base <= addr[9:0];
        tb_last <= len_last[2:0];
      end
      if (pend_set)
        pend <= 1'b1;
      else if (pend_clr)
        pend <= 1'b0;
      if (ar_we)
        ar[cmd_idx] <= arg[10:0];
      if (pw_we && cmd_sel)
        pw_w[cmd_idx] <= arg;
      if (pw_we && !cmd_sel)
        pw_r[cmd_idx] <= arg;
    end
  end

  // ==========================================================
  // Register read view and byte-lane merge
  reg [31:0] rd_word;

  always @*
  begin
    rd_word = 32'h00000000;
    case (wb_adr_i)
      `SEA_OFF_CTRL:   rd_word = {27'h0, ctrl};
      `SEA_OFF_STATUS: rd_word = {13'h0, last_trials, crst_act, pend, link_ready, last_ok,
                                  dev_busy, sc_ok, key_idx, pw_idx, pw_wr, pw_ok,
                                  auth_ok, sec_mode};
      `SEA_OFF_ARG:    rd_word = {8'h0, arg};
      `SEA_OFF_ADDR:   rd_word = {12'h0, addr};
      `SEA_OFF_RDATA:  rd_word = {24'h0, rdata};
      `SEA_OFF_MDC:    rd_word = (sec_mode == `SEA_MODE_STD) ? mdc : 32'h0;
      `SEA_OFF_MAC:    rd_word = {8'h0, mac_rx};
      default:
      begin
        if (wb_adr_i[7:4] == `SEA_OFF_WDAT_HI)
          rd_word = wdat[{wb_adr_i[3:2], 5'h00} +: 32];
      end
    endcase
  end

  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0]  s;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  wire [31:0] wm    = merge(rd_word, wb_dat_i, wb_sel_i);
  wire        wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ==========================================================
  // Bus slave, command engine and security state
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      sec_mode    <= `SEA_MODE_STD;
      dev_busy    <= 1'b1;
      state       <= S_START;
      ptr         <= 4'h0;
      last        <= 4'h0;
      auth_ok     <= 1'b0;
      key_idx     <= 2'h0;
      pw_ok       <= 1'b0;
      pw_wr       <= 1'b0;
      pw_idx      <= 3'h0;
      sc_ok       <= 1'b0;
      last_ok     <= 1'b0;
      last_trials <= 3'h0;
      ctrl        <= `SEA_CTRL_RST;
      arg         <= 24'h000000;
      addr        <= 20'h00000;
      mac_rx      <= 24'h000000;
      wdat        <= 128'h0;
      cmd_op      <= `SEA_OP_NOP;
      cmd_idx     <= 3'h0;
      cmd_sel     <= 1'b0;
      rdata       <= 8'h00;
      mdc         <= 32'h00000000;
      for (k = 0; k < 13; k = k + 1)
        trials[k] <= 3'h0;
    end
    else
    begin
      dev_busy <= (state != S_IDLE);
      case (state)
        // Resume an interrupted copy before anything else
        S_START:
        begin
          ptr   <= 4'h0;
          state <= pend ? S_COPY : S_IDLE;
        end
        S_IDLE:
        begin
          ptr <= 4'h0;
        end
        S_EXEC:
        begin
          state <= S_IDLE;
          mdc   <= {8'h0, arg} ^ {12'h0, addr} ^ wdat[31:0] ^ wdat[63:32] ^
                   wdat[95:64] ^ wdat[127:96];
          if (!mac_ok)
          begin
            sec_mode <= `SEA_MODE_STD;
            auth_ok  <= 1'b0;
            last_ok  <= 1'b0;
          end
          else if (is_trial)
          begin
            // A fresh attempt drops the old outcome first
            if (cmd_op == `SEA_OP_PW && !locked)
              pw_ok <= 1'b0;
            if (cmd_op == `SEA_OP_AUTH && !locked)
            begin
              auth_ok  <= 1'b0;
              sec_mode <= `SEA_MODE_STD;
            end
            if (locked)
              last_ok <= 1'b0;
            else
            begin
              last_ok     <= cmp_ok;
              trials[tix] <= cmp_ok ? 3'h0 : trial_now + 3'h1;
              last_trials <= cmp_ok ? 3'h0 : trial_now + 3'h1;
              if (cmp_ok)
              begin
                case (cmd_op)
                  `SEA_OP_SECURE: sc_ok <= 1'b1;
                  `SEA_OP_PW:
                  begin
                    pw_ok  <= 1'b1;
                    pw_wr  <= cmd_sel;
                    pw_idx <= cmd_idx;
                  end
                  `SEA_OP_AUTH:
                  begin
                    auth_ok  <= 1'b1;
                    key_idx  <= cmd_idx[1:0];
                    sec_mode <= `SEA_MODE_AUTH;
                  end
                  default: sec_mode <= `SEA_MODE_ENC;
                endcase
              end
              else if (cmd_op == `SEA_OP_SECURE)
                sc_ok <= 1'b0;
            end
          end
          else
          begin
            case (cmd_op)
              `SEA_OP_WRITE:
              begin
                last_ok <= wr_ok;
                last    <= len_last;
                if (wr_ok)
                  state <= tear ? S_BUF : S_DIRECT;
              end
              `SEA_OP_READ:
              begin
                last_ok <= rd_ok;
                rdata   <= rd_ok ? mem[addr[9:0]] : 8'h00;
              end
              `SEA_OP_CFG_AR: last_ok <= sc_ok;
              `SEA_OP_CFG_PW: last_ok <= sc_ok || super_ok;
              default:        last_ok <= 1'b0;
            endcase
          end
        end
        // Each step costs one write-cycle tick
        S_BUF:
        begin
          if (tick)
          begin
            ptr   <= (ptr == last) ? 4'h0 : ptr + 4'h1;
            state <= (ptr == last) ? S_COPY : S_BUF;
          end
        end
        S_COPY:
        begin
          if (tick)
          begin
            ptr   <= (ptr == {1'b0, tb_last}) ? 4'h0 : ptr + 4'h1;
            state <= (ptr == {1'b0, tb_last}) ? S_IDLE : S_COPY;
          end
        end
        S_DIRECT:
        begin
          if (tick)
          begin
            ptr   <= (ptr == last) ? 4'h0 : ptr + 4'h1;
            state <= (ptr == last) ? S_IDLE : S_DIRECT;
          end
        end
        default: state <= S_IDLE;
      endcase

      // Bus: one-cycle answer, unmapped reads give zero
      wb_ack_o <= wb_go;
      if (wb_go)
        wb_dat_o <= rd_word;
      if (wb_go && wb_we_i)
      begin
        case (wb_adr_i)
          `SEA_OFF_CTRL: ctrl   <= wm[4:0];
          `SEA_OFF_ARG:  arg    <= wm[23:0];
          `SEA_OFF_ADDR: addr   <= wm[19:0];
          `SEA_OFF_MAC:  mac_rx <= wm[23:0];
          `SEA_OFF_CMD:
          begin
            // Commands need an idle engine, an armed link and no card reset; others are dropped
            if (state == S_IDLE && link_ready && !crst_act)
            begin
              cmd_op  <= wm[3:0];
              cmd_idx <= wm[6:4];
              cmd_sel <= wm[7];
              state   <= S_EXEC;
            end
            else
              last_ok <= 1'b0;
          end
          default:
          begin
            if (wb_adr_i[7:4] == `SEA_OFF_WDAT_HI)
              wdat[{wb_adr_i[3:2], 5'h00} +: 32] <= wm;
          end
        endcase
      end

      // Card reset pin wipes the security state, not storage
      if (crst_act)
      begin
        sec_mode <= `SEA_MODE_STD;
        auth_ok  <= 1'b0;
        pw_ok    <= 1'b0;
        sc_ok    <= 1'b0;
      end
    end
  end

endmodule

// >>> verification/sea_access_checker.sv
`timescale 1ns/10ps
`include "sea_regs.vh"
// ============================================================
// Bus handshake and security mode checks
module sea_access_checker (
  input wire        clock,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        link_clk,
  input wire        card_rst,
  input wire        nv_erase,
  input wire [23:0] crypto_resp,
  input wire [23:0] crypto_mac,
  input wire [1:0]  sec_mode,
  input wire        dev_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Request waiting, then a single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follows: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_mode_legal: assert property (sec_mode != 2'h3)
    else $error("undefined security mode");
  a_enc_from_auth: assert property ((sec_mode == `SEA_MODE_ENC && $past(sec_mode) != `SEA_MODE_ENC)
    |-> $past(sec_mode) == `SEA_MODE_AUTH)
    else $error("encryption entered without authentication");
  a_mode_by_cmd: assert property ((sec_mode != `SEA_MODE_STD && sec_mode != $past(sec_mode))
    |-> $past(wb_ack_o && wb_we_i && wb_adr_i == `SEA_OFF_CMD))
    else $error("mode raised without a command");
  a_card_rst_std: assert property (card_rst [*8] |-> sec_mode == `SEA_MODE_STD)
    else $error("card reset left a secure mode");
  a_mdc_hidden: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == `SEA_OFF_MDC
    && sec_mode != `SEA_MODE_STD && $stable(sec_mode)) |-> wb_dat_o == 32'h0)
    else $error("detection code visible outside standard mode");
  a_reset_std: assert property ($past(rst) |-> sec_mode == `SEA_MODE_STD && dev_busy)
    else $error("not standard and busy after reset");
endmodule
bind sea_access_ctrl sea_access_checker sea_access_checker_i (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .link_clk(link_clk), .card_rst(card_rst), .nv_erase(nv_erase), .crypto_resp(crypto_resp),
  .crypto_mac(crypto_mac), .sec_mode(sec_mode), .dev_busy(dev_busy));

// >>> verification/sea_host_model.sv
`timescale 1ns/10ps
// ============================================================
// Host serial clock: five pulses per frame, still in between
module sea_host_model (
  input  wire frame,
  output reg  link_clk
);
  initial link_clk = 1'b0;
  // Levels last 80 ns, well above the three-flop sampling window
  always @(posedge frame)
    repeat (5)
    begin
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
endmodule

// >>> verification/sea_access_ctrl_tb.sv
`timescale 1ns/10ps
`include "sea_regs.vh"
// ============================================================
// Access control bench
module sea_access_ctrl_tb;
  localparam [23:0] CODE = 24'h5ac317; // Value is arbitrary
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, card_rst, nv_erase, frame;
  logic        wb_ack_o, link_clk, dev_busy;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [23:0] crypto_resp, crypto_mac, mac_val;
  logic [1:0]  sec_mode;
  logic [10:0] ar_tab [1:5] = '{11'h100, 11'h200, 11'h400, 11'h080, 11'h005};
  int          fail_count = 0, samples_checked = 0, cyc_count = 0, i;
  sea_access_ctrl #(.SECURE_CODE(CODE)) sea_access_ctrl_i (.clock(clock), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_clk(link_clk), .card_rst(card_rst), .nv_erase(nv_erase), .crypto_resp(crypto_resp),
    .crypto_mac(crypto_mac), .sec_mode(sec_mode), .dev_busy(dev_busy));
  sea_host_model sea_host_model_i (.frame(frame), .link_clk(link_clk));
  // ============================================================
  // Clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 40000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  // ============================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle, held until ack is sampled
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  // Host keeps polling while the engine is busy
  task poll;
    do xfer(1'b0, `SEA_OFF_STATUS, 32'h0); while (rd[11] !== 1'b0);
  endtask
  task cmd(input logic [3:0] op, input logic [3:0] idx);
    xfer(1'b1, `SEA_OFF_MAC, {8'h00, mac_val});
    xfer(1'b1, `SEA_OFF_CMD, {24'h0, idx, op});
    poll;
  endtask
  task arg(input logic [23:0] v);
    xfer(1'b1, `SEA_OFF_ARG, {8'h00, v});
  endtask
  task stat(input int b, input logic e);
    xfer(1'b0, `SEA_OFF_STATUS, 32'h0);
    check(rd[b], e);
  endtask
  task mode(input logic [1:0] e);
    xfer(1'b0, `SEA_OFF_STATUS, 32'h0);
    check(rd[1:0], e);
  endtask
  task wr(input logic [9:0] a, input logic [3:0] n1, input logic [31:0] w0);
    xfer(1'b1, {`SEA_OFF_WDAT_HI, 4'h0}, w0);
    xfer(1'b1, `SEA_OFF_ADDR, {12'h0, n1, 6'h0, a});
    cmd(`SEA_OP_WRITE, 4'h0);
  endtask
  task rdb(input logic [9:0] a, input logic [7:0] e);
    xfer(1'b1, `SEA_OFF_ADDR, {22'h0, a});
    cmd(`SEA_OP_READ, 4'h0);
    xfer(1'b0, `SEA_OFF_RDATA, 32'h0);
    check(rd[7:0], e);
  endtask
  // Five link pulses arm the command engine
  task arm;
    frame <= 1'b1;
    do xfer(1'b0, `SEA_OFF_STATUS, 32'h0); while (rd[13] !== 1'b1);
    frame <= 1'b0;
  endtask
  task report_and_stop;
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    {rst, nv_erase, wb_sel_i} = 6'h3f;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, card_rst, frame} = 0;
    crypto_resp = 24'h3c5a69;
    crypto_mac = 24'h00c0de;
    mac_val = 24'h00c0de;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    nv_erase <= 1'b0;
    @(posedge clock);
    poll;
    arm;
    mode(`SEA_MODE_STD);
    // Configuration locked until the secure code is shown
    cmd(`SEA_OP_CFG_AR, 4'h1); stat(12, 1'b0);
    arg(24'h000001); cmd(`SEA_OP_SECURE, 4'h0); stat(10, 1'b0);
    arg(CODE); cmd(`SEA_OP_SECURE, 4'h0); stat(10, 1'b1);
    for (i = 1; i < 6; i++)
    begin
      arg({13'h0, ar_tab[i]});
      cmd(`SEA_OP_CFG_AR, i[3:0]);
    end
    arg(24'h111111); cmd(`SEA_OP_CFG_PW, 4'ha);
    // Zone protections
    wr(10'h100, 4'h0, 32'h0f); wr(10'h100, 4'h0, 32'hf0); rdb(10'h100, 8'h00);
    wr(10'h180, 4'h0, 32'h12); stat(12, 1'b0); rdb(10'h180, 8'hff);
    wr(10'h080, 4'h1, 32'h55fd); rdb(10'h080, 8'hfd); rdb(10'h081, 8'hff);
    wr(10'h081, 4'h0, 32'h00); rdb(10'h081, 8'hff);
    wr(10'h082, 4'h0, 32'h00); rdb(10'h082, 8'h00);
    wr(10'h080, 4'h0, 32'hff); rdb(10'h080, 8'hfd);
    wr(10'h080, 4'h0, 32'hfc); wr(10'h080, 4'h0, 32'h00); rdb(10'h080, 8'hfc);
    rdb(10'h200, 8'h00); stat(12, 1'b0);
    // Modes and message codes
    arg(crypto_resp); cmd(`SEA_OP_AUTH, 4'h0); mode(`SEA_MODE_AUTH);
    cmd(`SEA_OP_ENC, 4'h0); mode(`SEA_MODE_ENC);
    xfer(1'b1, `SEA_OFF_ADDR, 32'h200); cmd(`SEA_OP_READ, 4'h0); stat(12, 1'b1);
    xfer(1'b0, `SEA_OFF_MDC, 32'h0); check(rd, 32'h0);
    // Password zone, then card reset drops it and the secure mode
    rdb(10'h280, 8'h00);
    arg(24'h111111); cmd(`SEA_OP_PW, 4'ha); stat(3, 1'b1); stat(4, 1'b1);
    rdb(10'h280, 8'hff);
    card_rst <= 1'b1;
    repeat (10) @(posedge clock);
    card_rst <= 1'b0;
    repeat (6) @(posedge clock);
    stat(3, 1'b0);
    mode(`SEA_MODE_STD);
    arm;
    arg(crypto_resp); cmd(`SEA_OP_AUTH, 4'h0); mode(`SEA_MODE_AUTH);
    mac_val = 24'h000bad;
    cmd(`SEA_OP_READ, 4'h0); mode(`SEA_MODE_STD); stat(12, 1'b0);
    mac_val = crypto_mac;
    // A failed retry cancels success; four failures lock the key
    arg(crypto_resp); cmd(`SEA_OP_AUTH, 4'h1); stat(2, 1'b1);
    arg(24'h0);
    repeat (4) cmd(`SEA_OP_AUTH, 4'h1);
    stat(2, 1'b0);
    arg(crypto_resp); cmd(`SEA_OP_AUTH, 4'h1); stat(2, 1'b0);
    // Tear protection: nine bytes asked, eight land
    xfer(1'b1, `SEA_OFF_CTRL, 32'h1);
    xfer(1'b1, 8'h24, 32'h88776655);
    xfer(1'b1, 8'h28, 32'h99);
    wr(10'h000, 4'h8, 32'h44332211); rdb(10'h007, 8'h88); rdb(10'h008, 8'hff);
    // Detection code of the last read: argument, address and write words folded
    xfer(1'b0, `SEA_OFF_MDC, 32'h0);
    check(rd, {8'h0, crypto_resp} ^ 32'h8 ^ 32'h44332211 ^ 32'h88776655 ^ 32'h99);
    // Power lost during the copy phase
    xfer(1'b1, `SEA_OFF_ADDR, {12'h0, 4'h7, 6'h0, 10'h010});
    xfer(1'b1, `SEA_OFF_CMD, {28'h0, `SEA_OP_WRITE});
    repeat (220) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    poll;
    arm;
    rdb(10'h010, 8'h11); rdb(10'h017, 8'h88);
    report_and_stop;
  end
endmodule
